// *** cell_fault_chk.sv ***
// port assertions for the cell fault diagnostics block
`timescale 1ns/1ps
module cell_fault_chk (
   // bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // events and fault outputs
   input wire logic sample_valid,
   input wire logic rail_valid,
   input wire logic wire_valid,
   input wire logic scan_wires_start,
   input wire logic [cell_fault_pkg::WIRES-1:0] wire_test_enable,
   input wire logic report_valid,
   input wire logic [cell_fault_pkg::FSTAT_W-1:0] report_data,
   input wire logic report_ready
);
   import cell_fault_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'h0) else $error("bus response not okay");
   chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
      !hreadyout ##1 hreadyout) else $error("read wait state wrong");
   chk_write_fast: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_low_wires_on: assert property (wire_test_enable[1:0] == 2'h3)
      else $error("low wires not tested");
   chk_scan_pulse: assert property (scan_wires_start |=> !scan_wires_start)
      else $error("scan start too long");
   chk_report_hold: assert property (report_valid && !report_ready |=>
      report_valid && $stable(report_data)) else $error("report dropped");
   chk_report_cause: assert property ($rose(report_valid) |-> report_data != 4'h0 &&
      $past(sample_valid || rail_valid || wire_valid)) else $error("report without event");
   chk_report_taken: assert property (report_valid && report_ready |=> !report_valid)
      else $error("report kept after accept");
endmodule
bind cell_fault_diagnostics cell_fault_chk i_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .sample_valid(sample_valid), .rail_valid(rail_valid),
   .wire_valid(wire_valid), .scan_wires_start(scan_wires_start),
   .wire_test_enable(wire_test_enable), .report_valid(report_valid),
   .report_data(report_data), .report_ready(report_ready));

// *** cell_fault_diagnostics.sv ***
// undervoltage, pack connection and open-wire fault detection with ahb-lite registers
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module cell_fault_diagnostics (
   // ahb-lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [cell_fault_pkg::DATA_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [cell_fault_pkg::DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [cell_fault_pkg::DATA_W-1:0] hrdata,
   // cell voltage samples from the measurement front end
   input wire logic sample_valid,
   input wire logic [cell_fault_pkg::IDX_W-1:0] sample_cell,
   input wire logic [cell_fault_pkg::CODE_W-1:0] sample_code,
   // pack supply and ground connection results
   input wire logic rail_valid,
   input wire logic supply_open,
   input wire logic ground_open,
   // open-wire scan
   output logic scan_wires_start,
   output logic [cell_fault_pkg::WIRES-1:0] wire_test_enable,
   output logic scan_current_select,
   input wire logic wire_valid,
   input wire logic [cell_fault_pkg::IDX_W-1:0] wire_index,
   input wire logic wire_open,
   input wire logic wire_scan_done,
   // automatic fault status report
   output logic report_valid,
   output logic [cell_fault_pkg::FSTAT_W-1:0] report_data,
   input wire logic report_ready,
   // interrupt
   output logic irq
);
   import cell_fault_pkg::*;

   bus_state_type bus_q;
   logic [ADDR_W-1:0] addr_q;
   logic wr_q;
   logic [DATA_W-1:0] hrdata_q;
   logic [DATA_W-1:0] rd_value;
   logic addr_ok;
   logic wr_en;

   logic scan_cur_q;
   logic [2:0] filter_sel_q;
   logic [CELLS-1:0] cell_setup_q;
   logic [CODE_W-1:0] uv_limit_q;
   logic [FSTAT_W-1:0] fault_status_q;
   logic [CELLS-1:0] uv_fault_q;
   logic [WIRES-1:0] ow_fault_q;
   logic busy_q;
   logic start_q;
   logic [EVT_W-1:0] irq_status_q;
   logic [EVT_W-1:0] irq_enable_q;
   logic report_valid_q;
   logic [FSTAT_W-1:0] report_data_q;

   logic [CNT_W-1:0] uv_cnt_q [CELLS];
   logic [CNT_W-1:0] supply_cnt_q;
   logic [CNT_W-1:0] ground_cnt_q;
   logic [CNT_W-1:0] target;
   logic filter_clr;

   logic [CELLS-1:0] uv_hit;
   logic supply_hit;
   logic ground_hit;
   logic [WIRES-1:0] wire_hit;
   logic [FSTAT_W-1:0] fs_set;
   logic [EVT_W-1:0] evt;

   // bus front: writes finish without wait, reads take one wait state
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign wr_en = wr_q;
   assign hreadyout = (bus_q != BUS_READ);
   assign hresp = 1'b0;
   // read data is captured in the wait state and holds until the next read
   assign hrdata = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q <= BUS_IDLE;
         addr_q <= 8'h00;
         wr_q <= 1'b0;
      end else begin
         wr_q <= addr_ok && hwrite;
         // only the low address bits are decoded, upper bits alias
         if (addr_ok) begin
            addr_q <= haddr[ADDR_W-1:0];
         end
         case (bus_q)
            BUS_IDLE: begin
               if (addr_ok && !hwrite) begin
                  bus_q <= BUS_READ;
               end
            end
            BUS_READ: begin
               bus_q <= BUS_IDLE;
            end
            default: begin
               bus_q <= BUS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      rd_value = '0;
      case (addr_q)
         DEV_SETUP_OFS: rd_value[SCAN_CUR_BIT] = scan_cur_q;
         FAULT_SETUP_OFS: rd_value[2:0] = filter_sel_q;
         CELL_SETUP_OFS: rd_value[CELLS-1:0] = cell_setup_q;
         UV_LIMIT_OFS: rd_value[CODE_W-1:0] = uv_limit_q;
         FAULT_STATUS_OFS: rd_value[FSTAT_W-1:0] = fault_status_q;
         UV_FAULT_OFS: rd_value[CELLS-1:0] = uv_fault_q;
         OW_FAULT_OFS: rd_value[WIRES-1:0] = ow_fault_q;
         COMMAND_OFS: rd_value[SCAN_WIRES_BIT] = busy_q;
         IRQ_STATUS_OFS: rd_value[EVT_W-1:0] = irq_status_q;
         IRQ_ENABLE_OFS: rd_value[EVT_W-1:0] = irq_enable_q;
         // irq clear is write only and reads back as zero
         default: rd_value = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (bus_q == BUS_READ) begin
         hrdata_q <= rd_value;
      end
   end

   // setup registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_cur_q <= SCAN_CUR_RST;
         filter_sel_q <= FILTER_SEL_RST;
         cell_setup_q <= CELL_SETUP_RST;
         uv_limit_q <= UV_LIMIT_RST;
         irq_enable_q <= '0;
      end else if (wr_en) begin
         case (addr_q)
            DEV_SETUP_OFS: scan_cur_q <= hwdata[SCAN_CUR_BIT];
            FAULT_SETUP_OFS: filter_sel_q <= hwdata[2:0];
            CELL_SETUP_OFS: cell_setup_q <= hwdata[CELLS-1:0];
            UV_LIMIT_OFS: uv_limit_q <= hwdata[CODE_W-1:0];
            IRQ_ENABLE_OFS: irq_enable_q <= hwdata[EVT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   assign scan_current_select = scan_cur_q;

   // consecutive sample target: code n selects 2**n samples
   assign target = CNT_W'(1) << filter_sel_q;
   assign filter_clr = wr_en && addr_q == FAULT_SETUP_OFS
      && hwdata[2:0] != filter_sel_q;

   // per-cell undervoltage filters
   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_uv
         logic mine;
         logic low;
         // a cell number outside one to twelve matches no filter and is dropped
         assign mine = sample_valid && sample_cell == IDX_W'(gi + 1);
         assign low = sample_code < uv_limit_q;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               uv_cnt_q[gi] <= '0;
            end else if (filter_clr) begin
               uv_cnt_q[gi] <= '0;
            end else if (mine) begin
               if (low && !cell_setup_q[gi]) begin
                  // the count stops at the target so a long run cannot wrap
                  if (uv_cnt_q[gi] != target) begin
                     uv_cnt_q[gi] <= uv_cnt_q[gi] + CNT_W'(1);
                  end
               end else begin
                  uv_cnt_q[gi] <= '0;
               end
            end
         end
         // fires on the sample that completes the run
         assign uv_hit[gi] = mine && low && !cell_setup_q[gi] && !filter_clr
            && uv_cnt_q[gi] + CNT_W'(1) >= target;
      end
   endgenerate

   // pack supply and ground open filters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_cnt_q <= '0;
         ground_cnt_q <= '0;
      end else if (filter_clr) begin
         supply_cnt_q <= '0;
         ground_cnt_q <= '0;
      end else if (rail_valid) begin
         if (!supply_open) begin
            supply_cnt_q <= '0;
         end else if (supply_cnt_q != target) begin
            supply_cnt_q <= supply_cnt_q + CNT_W'(1);
         end
         if (!ground_open) begin
            ground_cnt_q <= '0;
         end else if (ground_cnt_q != target) begin
            ground_cnt_q <= ground_cnt_q + CNT_W'(1);
         end
      end
   end

   assign supply_hit = rail_valid && supply_open && !filter_clr
      && supply_cnt_q + CNT_W'(1) >= target;
   assign ground_hit = rail_valid && ground_open && !filter_clr
      && ground_cnt_q + CNT_W'(1) >= target;

   // open-wire scan
   always_comb begin
      wire_test_enable = '1;
      for (int i = 2; i < WIRES; i++) begin
         wire_test_enable[i] = !cell_setup_q[i-1];
      end
   end

   always_comb begin
      wire_hit = '0;
      for (int i = 0; i < WIRES; i++) begin
         // results outside a running scan are ignored
         wire_hit[i] = wire_valid && busy_q && wire_open
            && wire_index == IDX_W'(i) && wire_test_enable[i];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (busy_q && wire_scan_done) begin
            busy_q <= 1'b0;
         // a second command during a running scan is ignored
         end else if (!busy_q && wr_en && addr_q == COMMAND_OFS
               && hwdata[SCAN_WIRES_BIT]) begin
            busy_q <= 1'b1;
            start_q <= 1'b1;
         end
      end
   end

   assign scan_wires_start = start_q;

   // fault registers: write one to clear, a same-cycle set wins
   assign fs_set[FS_UV_BIT] = |uv_hit;
   assign fs_set[FS_SUPPLY_BIT] = supply_hit;
   assign fs_set[FS_GROUND_BIT] = ground_hit;
   assign fs_set[FS_WIRE_BIT] = |wire_hit;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_status_q <= '0;
         uv_fault_q <= '0;
         ow_fault_q <= '0;
      end else begin
         if (wr_en && addr_q == FAULT_STATUS_OFS) begin
            fault_status_q <= (fault_status_q & ~hwdata[FSTAT_W-1:0]) | fs_set;
         end else begin
            fault_status_q <= fault_status_q | fs_set;
         end
         if (wr_en && addr_q == UV_FAULT_OFS) begin
            uv_fault_q <= (uv_fault_q & ~hwdata[CELLS-1:0]) | uv_hit;
         end else begin
            uv_fault_q <= uv_fault_q | uv_hit;
         end
         if (wr_en && addr_q == OW_FAULT_OFS) begin
            ow_fault_q <= (ow_fault_q & ~hwdata[WIRES-1:0]) | wire_hit;
         end else begin
            ow_fault_q <= ow_fault_q | wire_hit;
         end
      end
   end

   // unsolicited status report toward the host link
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         report_valid_q <= 1'b0;
         report_data_q <= '0;
      // only a fault arriving on a clear status is sent, later ones are not sent until a write clears the status
      end else if (fault_status_q == '0 && fs_set != '0) begin
         report_valid_q <= 1'b1;
         report_data_q <= fs_set;
      end else if (report_ready) begin
         report_valid_q <= 1'b0;
      end
   end

   assign report_valid = report_valid_q;
   assign report_data = report_data_q;

   // interrupt events
   assign evt[EV_UV_BIT] = |uv_hit;
   assign evt[EV_CONN_BIT] = supply_hit || ground_hit;
   assign evt[EV_WIRE_BIT] = |wire_hit;
   assign evt[EV_DONE_BIT] = busy_q && wire_scan_done;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_q <= '0;
      end else if (wr_en && addr_q == IRQ_CLEAR_OFS) begin
         irq_status_q <= (irq_status_q & ~hwdata[EVT_W-1:0]) | evt;
      end else begin
         irq_status_q <= irq_status_q | evt;
      end
   end

   assign irq = |(irq_status_q & irq_enable_q);
endmodule

// *** cell_fault_diagnostics_test.sv ***
// self-checking bench for the cell fault diagnostics block
`timescale 1ns/1ps
module cell_fault_diagnostics_test;
   import cell_fault_pkg::*;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d;} row_type;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, stall = 1'h1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, reports, rdv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic sample_valid = 1'h0, rail_valid = 1'h0, supply_open = 1'h0, ground_open = 1'h0;
   logic wire_valid = 1'h0, wire_open = 1'h0, wire_scan_done = 1'h0;
   logic [3:0] sample_cell = 4'h0, wire_index = 4'h0, report_data, last_report;
   logic [13:0] sample_code = 14'h0;
   logic [12:0] wire_test_enable;
   logic hreadyout, hresp, scan_wires_start, scan_current_select, report_valid;
   logic report_ready, irq;
   int fail_count = 0, checks = 0;
   row_type rows [10] = '{'{FAULT_SETUP_OFS, 1'h0, 32'h3}, '{UV_LIMIT_OFS, 1'h0, 32'h1FFF},
      '{DEV_SETUP_OFS, 1'h0, 32'h0}, '{CELL_SETUP_OFS, 1'h0, 32'h0},
      '{FAULT_STATUS_OFS, 1'h0, 32'h0}, '{8'h40, 1'h1, 32'h5}, '{8'h40, 1'h0, 32'h0},
      '{IRQ_ENABLE_OFS, 1'h1, 32'hF}, '{IRQ_ENABLE_OFS, 1'h0, 32'hF},
      '{IRQ_STATUS_OFS, 1'h0, 32'h0}};
   always #5 hclk = ~hclk;
   cell_fault_diagnostics i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
      .sample_cell(sample_cell), .sample_code(sample_code), .rail_valid(rail_valid),
      .supply_open(supply_open), .ground_open(ground_open), .scan_wires_start(scan_wires_start),
      .wire_test_enable(wire_test_enable), .scan_current_select(scan_current_select),
      .wire_valid(wire_valid), .wire_index(wire_index), .wire_open(wire_open),
      .wire_scan_done(wire_scan_done), .report_valid(report_valid), .report_data(report_data),
      .report_ready(report_ready), .irq(irq));
   report_host i_host (.hclk(hclk), .hresetn(hresetn), .report_valid(report_valid),
      .report_data(report_data), .report_ready(report_ready), .stall(stall),
      .last_report(last_report), .reports(reports));
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rdv = hrdata;
      hsel <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk("register read", rdv, e);
   endtask
   task automatic smp(input int c, input logic [13:0] v, input int n);
      repeat (n) begin
         @(posedge hclk);
         sample_valid <= 1'h1;
         sample_cell <= 4'(c);
         sample_code <= v;
      end
      @(posedge hclk);
      sample_valid <= 1'h0;
   endtask
   task automatic rail(input logic s, input logic g, input int n);
      repeat (n) begin
         @(posedge hclk);
         rail_valid <= 1'h1;
         supply_open <= s;
         ground_open <= g;
      end
      @(posedge hclk);
      rail_valid <= 1'h0;
   endtask
   task automatic wpulse(input int i, input logic o, input logic d);
      @(posedge hclk);
      wire_valid <= !d;
      wire_scan_done <= d;
      wire_index <= 4'(i);
      wire_open <= o;
      @(posedge hclk);
      wire_valid <= 1'h0;
      wire_scan_done <= 1'h0;
   endtask
   task automatic end_of_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge hclk);
      @(negedge hclk);
      chk("reset wire enables", wire_test_enable, 32'h1FFF);
      @(posedge hclk) hresetn <= 1'h1;
      foreach (rows[i]) begin
         if (rows[i].w) bus(1'h1, rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d);
      end
      bus(1'h1, CELL_SETUP_OFS, 32'h010);
      smp(3, 14'h0, 7);
      smp(3, 14'h1FFF, 1);
      smp(4, 14'h0, 4);
      smp(3, 14'h0, 7);
      smp(5, 14'h0, 8);
      rd(FAULT_STATUS_OFS, 32'h0);
      smp(3, 14'h0, 1);
      @(negedge hclk);
      chk("report", {irq, report_valid, report_data}, 32'h31);
      rd(UV_FAULT_OFS, 32'h004);
      stall <= 1'h0;
      bus(1'h1, UV_FAULT_OFS, 32'h004);
      bus(1'h1, FAULT_STATUS_OFS, 32'h1);
      bus(1'h1, IRQ_CLEAR_OFS, 32'hF);
      rd(FAULT_STATUS_OFS, 32'h0);
      chk("host got report", {irq, reports[3:0], last_report}, 32'h11);
      bus(1'h1, FAULT_SETUP_OFS, 32'h2);
      smp(6, 14'h0, 4);
      smp(7, 14'h0, 3);
      bus(1'h1, FAULT_SETUP_OFS, 32'h3);
      bus(1'h1, FAULT_SETUP_OFS, 32'h2);
      smp(7, 14'h0, 1);
      rd(UV_FAULT_OFS, 32'h020);
      bus(1'h1, UV_FAULT_OFS, 32'h020);
      bus(1'h1, FAULT_STATUS_OFS, 32'h1);
      bus(1'h1, IRQ_CLEAR_OFS, 32'h1);
      rail(1'h1, 1'h1, 3);
      rail(1'h0, 1'h0, 1);
      rail(1'h1, 1'h1, 3);
      rd(FAULT_STATUS_OFS, 32'h0);
      rail(1'h1, 1'h1, 1);
      rd(FAULT_STATUS_OFS, 32'h6);
      bus(1'h1, FAULT_STATUS_OFS, 32'h6);
      rd(FAULT_STATUS_OFS, 32'h0);
      bus(1'h1, DEV_SETUP_OFS, 32'h1);
      bus(1'h1, CELL_SETUP_OFS, 32'hFFF);
      @(negedge hclk);
      chk("current and wires", {scan_current_select, wire_test_enable}, 32'h2003);
      bus(1'h1, CELL_SETUP_OFS, 32'h010);
      @(negedge hclk);
      chk("wire enables", wire_test_enable, 32'h1FDF);
      wpulse(1, 1'h1, 1'h0);
      bus(1'h1, COMMAND_OFS, 32'h1);
      for (int i = 0; i < 20 && scan_wires_start !== 1'h1; i++) @(negedge hclk);
      chk("scan start", scan_wires_start, 32'h1);
      wpulse(0, 1'h1, 1'h0);
      wpulse(5, 1'h1, 1'h0);
      wpulse(2, 1'h0, 1'h0);
      wpulse(0, 1'h0, 1'h1);
      rd(FAULT_STATUS_OFS, 32'h8);
      rd(OW_FAULT_OFS, 32'h1);
      rd(IRQ_STATUS_OFS, 32'hE);
      chk("wire report", {irq, last_report}, 32'h18);
      @(posedge hclk) hresetn <= 1'h0;
      @(negedge hclk);
      chk("reset outputs", {irq, report_valid, scan_current_select}, 32'h0);
      @(posedge hclk) hresetn <= 1'h1;
      rd(FAULT_SETUP_OFS, 32'h3);
      end_of_test;
   end
endmodule

// *** cell_fault_pkg.sv ***
// shared constants for the cell fault diagnostics block
package cell_fault_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CELLS = 12;
   localparam int WIRES = 13;
   localparam int IDX_W = 4;
   localparam int CODE_W = 14;
   localparam int CNT_W = 8;
   localparam int FSTAT_W = 4;
   localparam int EVT_W = 4;
   // register byte offsets
   localparam logic [ADDR_W-1:0] DEV_SETUP_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] FAULT_SETUP_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] CELL_SETUP_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] UV_LIMIT_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] UV_FAULT_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] OW_FAULT_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] COMMAND_OFS = 8'h1C;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 8'h24;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h28;
   // field positions and reset values
   localparam int SCAN_CUR_BIT = 0;
   localparam int SCAN_WIRES_BIT = 0;
   localparam int FS_UV_BIT = 0;
   localparam int FS_SUPPLY_BIT = 1;
   localparam int FS_GROUND_BIT = 2;
   localparam int FS_WIRE_BIT = 3;
   localparam int EV_UV_BIT = 0;
   localparam int EV_CONN_BIT = 1;
   localparam int EV_WIRE_BIT = 2;
   localparam int EV_DONE_BIT = 3;
   localparam logic [2:0] FILTER_SEL_RST = 3'h3;
   localparam logic [CODE_W-1:0] UV_LIMIT_RST = 14'h1FFF;
   localparam logic [0:0] SCAN_CUR_RST = 1'h0;
   localparam logic [CELLS-1:0] CELL_SETUP_RST = 12'h000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_READ = 2'b10
   } bus_state_type;
endpackage

// *** report_host.sv ***
// host model that accepts unsolicited fault status reports
`timescale 1ns/1ps
module report_host (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // report channel
   input wire logic report_valid,
   input wire logic [cell_fault_pkg::FSTAT_W-1:0] report_data,
   output logic report_ready,
   // bench control and results
   input wire logic stall,
   output logic [cell_fault_pkg::FSTAT_W-1:0] last_report,
   output logic [31:0] reports
);
   import cell_fault_pkg::*;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) report_ready <= 1'h0;
      else report_ready <= !stall;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_report <= '0;
         reports <= 32'h0;
      end else if (report_valid && report_ready) begin
         last_report <= report_data;
         reports <= reports + 32'h1;
      end
   end
endmodule
